// File: bench/icu_pin_src.sv
// Pulse source model driving capture pins and time base clock lines
`timescale 1ns/1ps
`default_nettype none
module icu_pin_src (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // Request: toggle one line a number of times
  input wire logic start_i,
  input wire logic [3:0] line_i,
  input wire logic [5:0] tog_i,
  // Lines
  output logic busy_o,
  output logic [10:0] line_o
);
  logic [5:0] left_r;
  logic [3:0] sel_r;
  logic ph_r;
  // Each level stands two cycles so the block sees every edge once
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      left_r <= 6'h00;
      sel_r <= 4'h0;
      ph_r <= 1'b0;
      line_o <= 11'h000;
    end else if (start_i && left_r == 6'h00) begin
      left_r <= tog_i;
      sel_r <= line_i;
      ph_r <= 1'b0;
    end else if (left_r != 6'h00) begin
      ph_r <= ~ph_r;
      if (ph_r) begin
        line_o[sel_r] <= ~line_o[sel_r];
        left_r <= left_r - 6'h01;
      end
    end
  end
  assign busy_o = (left_r != 6'h00);
endmodule : icu_pin_src
`default_nettype wire

// File: bench/icu_top_sva.sv
// Concurrent checks on the ports of the input capture block
`timescale 1ns/1ps
`default_nettype none
`include "icu_map.svh"
module icu_top_sva (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // Register bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // Pins and status
  input wire logic unit1_pin_i,
  input wire logic [4:0] pin_out_o,
  input wire logic [4:0] pin_oe_o,
  input wire logic [4:0] capture_flag_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  logic take;
  logic wr8;
  logic fwr;
  logic pin_r;
  logic [3:0] age_r;
  assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr8 = take && wb_we_i && wb_sel_i[0];
  assign fwr = wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0] && wb_adr_i[7:2] == `ICU_IDX_FLAG;
  // Cycles since unit 1 pin last changed, saturating
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_r <= 1'b0;
      age_r <= 4'hF;
    end else begin
      pin_r <= unit1_pin_i;
      if (unit1_pin_i != pin_r) age_r <= 4'h0;
      else if (age_r != 4'hF) age_r <= age_r + 4'h1;
    end
  end
  ack_wait_a: assert property (take |=> wb_ack_o) else $error("ack missing");
  ack_once_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  ack_idle_a: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o) else $error("stray ack");
  unmapped_zero_a: assert property (
    take && !wb_we_i && wb_adr_i[7:2] > 6'h1B |=> wb_dat_o == 32'h0) else $error("unmapped read");
  flag_hold_a: assert property (
    (|($past(capture_flag_o) & ~capture_flag_o)) |-> $past(fwr) || $past(fwr, 2))
    else $error("flag cleared without write");
  flag_cause_a: assert property (
    $rose(capture_flag_o[0]) |-> age_r <= 4'h8 || $past(fwr) || $past(fwr, 2))
    else $error("flag without pin edge");
  dir_drive_a: assert property (
    wr8 && wb_adr_i[7:2] == `ICU_IDX_DIR |=> ##1 pin_oe_o == ~$past(wb_dat_i[4:0], 2))
    else $error("drive enable wrong");
  lat_drive_a: assert property (
    wr8 && wb_adr_i[7:2] == `ICU_IDX_LAT |=> ##1 pin_out_o == $past(wb_dat_i[4:0], 2))
    else $error("pin latch wrong");
  reset_quiet_a: assert property (
    $rose(rst_n_i) |-> !wb_ack_o && pin_oe_o == 5'h00 && capture_flag_o == 5'h00)
    else $error("state after reset");
endmodule : icu_top_sva
bind icu_top icu_top_sva u_sva (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .unit1_pin_i(unit1_pin_i),
  .pin_out_o(pin_out_o), .pin_oe_o(pin_oe_o), .capture_flag_o(capture_flag_o));
`default_nettype wire

// File: bench/testbench.sv
// Self-checking bench for the five-unit input capture block
`timescale 1ns/1ps
`default_nettype none
`include "icu_map.svh"
module testbench;
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic cyc = 1'b0, we = 1'b0, sleep = 1'b0, start = 1'b0;
  logic [3:0] sel = 4'h0, line = 4'h0;
  logic [5:0] tog = 6'h00;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0, dat_o;
  logic ack, busy, u1, u4, u5;
  logic [4:0] pout, poe, flag;
  logic [10:0] ln;
  logic [31:0] exp_q[$];
  logic [15:0] cnt[3];
  logic [15:0] v;
  int num_errors = 0, tests_run = 0, seed = 32'h5845BFC3;
  // Wire level of units 1, 4 and 5: the block drives the pin when enabled, else the source does
  assign u1 = poe[0] ? pout[0] : ln[0];
  assign u4 = poe[3] ? pout[3] : ln[5];
  assign u5 = poe[4] ? pout[4] : ln[6];
  icu_top u_dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .ce_i(1'b1), .wb_cyc_i(cyc),
    .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .unit1_pin_i(u1), .port_b_bit3_pin_i(ln[1]),
    .port_c_bit1_pin_i(ln[2]), .port_c_bit6_pin_i(ln[3]), .port_b_bit5_pin_i(ln[4]),
    .unit4_pin_i(u4), .unit5_pin_i(u5), .pin_out_o(pout), .pin_oe_o(poe), .sleep_i(sleep),
    .sosc_i(ln[7]), .timer_external_clock_in_i(ln[10:8]), .capture_flag_o(flag));
  icu_pin_src u_src (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .start_i(start), .line_i(line),
    .tog_i(tog), .busy_o(busy), .line_o(ln));
  initial begin
    forever #2.5 clk_sys_i = ~clk_sys_i;
  end
  task automatic results();
    $display("Mismatches %0d, checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : results
  task automatic cmp(input logic [31:0] got, input logic [31:0] want);
    tests_run++;
    if (got !== want) begin
      num_errors++;
      $display("[ERR] %0t read %h expected %h", $time, got, want);
    end
  endtask : cmp
  // Read results are judged by the monitor when the answer arrives
  always @(posedge clk_sys_i) begin
    if (ack === 1'b1 && cyc && !we) begin
      if (exp_q.size() == 0) begin
        num_errors++;
        $display("[ERR] %0t read without expectation", $time);
      end else cmp(dat_o, exp_q.pop_front());
    end
  end
  task automatic bus(input int idx, input logic w, input logic [31:0] d);
    adr <= 8'(idx * 4);
    we <= w;
    sel <= 4'h3;
    dat <= d;
    cyc <= 1'b1;
    // Only ack or the watchdog ends a wait for the answer
    do begin
      @(posedge clk_sys_i);
    end while (ack !== 1'b1);
    cyc <= 1'b0;
    @(posedge clk_sys_i);
  endtask : bus
  task automatic rd(input int idx, input logic [31:0] e);
    exp_q.push_back(e);
    bus(idx, 1'b0, 32'h0);
  endtask : rd
  task automatic wr(input int idx, input logic [31:0] d);
    bus(idx, 1'b1, d);
  endtask : wr
  task automatic pulse(input int l, input int t);
    line <= 4'(l);
    tog <= 6'(t);
    start <= 1'b1;
    @(posedge clk_sys_i);
    start <= 1'b0;
    do begin
      @(negedge clk_sys_i);
    end while (busy);
    repeat (6) @(posedge clk_sys_i);
  endtask : pulse
  task automatic ev(input int l, input int t, input logic [4:0] f);
    pulse(l, t);
    rd(`ICU_IDX_FLAG, {27'h0, f});
    wr(`ICU_IDX_FLAG, 32'h0);
  endtask : ev
  task automatic mode(input int u, input logic [3:0] m);
    wr(`ICU_IDX_CTRL_BASE + u, {28'h0, m});
    wr(`ICU_IDX_FLAG, 32'h0);
  endtask : mode
  initial begin
    repeat (2) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    rd(`ICU_IDX_ROUTE, 32'h1);
    rd(`ICU_IDX_DIR, 32'h1F);
    rd(6'h3F, 32'h0);
    for (int t = 0; t < 3; t++) begin
      cnt[t] = 16'($random(seed));
      wr(`ICU_IDX_TCNT_BASE + t, {16'h0, cnt[t]});
    end
    mode(0, `ICU_MODE_RISE);
    for (int s = 0; s < 4; s++) begin
      wr(`ICU_IDX_TSEL_A, 32'(s));
      pulse(0, 2);
      rd(`ICU_IDX_VAL_BASE, {24'h0, cnt[s % 3][7:0]});
      rd(`ICU_IDX_VAL_BASE + 1, {24'h0, cnt[s % 3][15:8]});
      ev(0, 0, 5'h01);
    end
    pulse(0, 2);
    cnt[0] = 16'($random(seed));
    wr(`ICU_IDX_TCNT_BASE, {16'h0, cnt[0]});
    ev(0, 2, 5'h01);
    rd(`ICU_IDX_VAL_BASE, {24'h0, cnt[0][7:0]});
    rd(`ICU_IDX_VAL_BASE + 1, {24'h0, cnt[0][15:8]});
    mode(0, `ICU_MODE_FALL);
    ev(0, 1, 5'h00);
    ev(0, 1, 5'h01);
    mode(0, `ICU_MODE_RISE);
    ev(0, 1, 5'h01);
    ev(0, 1, 5'h00);
    mode(0, `ICU_MODE_OFF);
    mode(0, `ICU_MODE_RISE4);
    ev(0, 6, 5'h00);
    ev(0, 2, 5'h01);
    ev(0, 4, 5'h00);
    mode(0, `ICU_MODE_RISE16);
    ev(0, 18, 5'h00);
    ev(0, 2, 5'h01);
    ev(0, 4, 5'h00);
    mode(0, `ICU_MODE_OFF);
    mode(0, `ICU_MODE_RISE4);
    ev(0, 6, 5'h00);
    ev(0, 2, 5'h01);
    mode(1, `ICU_MODE_RISE);
    ev(1, 2, 5'h00);
    ev(2, 2, 5'h02);
    wr(`ICU_IDX_ROUTE, 32'h0);
    ev(1, 2, 5'h02);
    mode(2, `ICU_MODE_RISE);
    ev(4, 2, 5'h00);
    ev(3, 2, 5'h04);
    wr(`ICU_IDX_ROUTE, 32'h4);
    ev(4, 2, 5'h04);
    mode(4, `ICU_MODE_RISE);
    wr(`ICU_IDX_DIR, 32'h0F);
    wr(`ICU_IDX_LAT, 32'h10);
    ev(0, 0, 5'h10);
    wr(`ICU_IDX_LAT, 32'h0);
    wr(`ICU_IDX_DIR, 32'h1F);
    wr(`ICU_IDX_FLAG, 32'h0);
    sleep <= 1'b1;
    for (int s = 0; s < 2; s++) begin
      wr(`ICU_IDX_TCTL_BASE, 32'(s * 2 + 1));
      wr(`ICU_IDX_TCNT_BASE, {16'h0, cnt[0]});
      pulse(0, 0);
      rd(`ICU_IDX_TCNT_BASE, {16'h0, cnt[0]});
    end
    wr(`ICU_IDX_TCTL_BASE + 1, 32'h5);
    wr(`ICU_IDX_TCNT_BASE + 1, {16'h0, cnt[1]});
    pulse(7, 6);
    rd(`ICU_IDX_TCNT_BASE + 1, {16'h0, cnt[1] + 16'h3});
    wr(`ICU_IDX_TCTL_BASE + 2, 32'h7);
    wr(`ICU_IDX_TCNT_BASE + 2, {16'h0, cnt[2]});
    pulse(10, 8);
    v = cnt[2] + 16'h4;
    rd(`ICU_IDX_TCNT_BASE + 2, {16'h0, v});
    wr(`ICU_IDX_TSEL_A, 32'h2);
    mode(0, `ICU_MODE_RISE);
    ev(0, 2, 5'h01);
    rd(`ICU_IDX_VAL_BASE, {24'h0, v[7:0]});
    rd(`ICU_IDX_VAL_BASE + 1, {24'h0, v[15:8]});
    sleep <= 1'b0;
    // Timer 0 runs from the system clock again: one count per cycle
    repeat (4) @(posedge clk_sys_i);
    rd(`ICU_IDX_TCNT_BASE, {16'h0, cnt[0] + 16'h4});
    results();
  end
  // A run of this length needs a few thousand cycles at most
  initial begin
    repeat (30000) @(posedge clk_sys_i);
    num_errors++;
    results();
  end
endmodule : testbench
`default_nettype wire

// File: core/icu_edge_unit.sv
// Pin synchroniser, edge detector and edge prescaler of one capture unit
`timescale 1ns/1ps
`default_nettype none
`include "icu_map.svh"
module icu_edge_unit (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // Pin level and mode
  input wire logic pin_i,
  input wire icu_pkg::icu_mode_t mode_i,
  // Capture event
  output logic capture_o
);
  logic sync1_r, sync2_r, prev_r, rise, fall;
  logic [3:0] pscnt_r;
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      prev_r <= 1'b0;
    end else if (ce_i) begin
      sync1_r <= pin_i;
      sync2_r <= sync1_r;
      prev_r <= sync2_r;
    end
  end
  assign rise = sync2_r & ~prev_r;
  assign fall = ~sync2_r & prev_r;
  // Count is kept across prescale changes, so switching can fire early
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pscnt_r <= 4'h0;
    end else if (ce_i) begin
      if (!icu_pkg::icu_is_capture(mode_i)) pscnt_r <= 4'h0;
      else if (rise) pscnt_r <= pscnt_r + 4'h1;
    end
  end
  always_comb begin
    case (mode_i)
      `ICU_MODE_FALL: capture_o = fall;
      `ICU_MODE_RISE: capture_o = rise;
      `ICU_MODE_RISE4: capture_o = rise && ((pscnt_r & `ICU_PS4_MASK) == `ICU_PS4_MASK);
      `ICU_MODE_RISE16: capture_o = rise && (pscnt_r == `ICU_PS16_MASK);
      default: capture_o = 1'b0;
    endcase
  end
endmodule : icu_edge_unit
`default_nettype wire

// File: core/icu_map.svh
// Register indices, field positions, codes and reset values of the input capture unit
// Notes on behaviour
// - Each unit picks one of three timers
// - Qualifying pin event copies selected timer count
// - Mode picks falling, rising, 4th or 16th rise
// - Every capture sets the unit event flag
// - New capture overwrites an unread held value
// - Output pin port writes can trigger captures
// - Units 2 and 3 follow pin route bits
// - Mode change may raise a spurious flag
// - Prescaler held clear outside capture mode
// - Any reset clears the prescaler counter
// - Prescale switch keeps count, may falsely capture
// - Timer clock: system, instruction, secondary, external
// - Internal clocked timer holds during sleep
// - External clocked capture continues during sleep
`ifndef ICU_MAP_SVH
`define ICU_MAP_SVH
// Word indices; byte address is four times the index
`define ICU_IDX_CTRL_BASE 6'h00
`define ICU_IDX_VAL_BASE 6'h05
`define ICU_IDX_TSEL_A 6'h0F
`define ICU_IDX_TSEL_B 6'h10
`define ICU_IDX_FLAG 6'h11
`define ICU_IDX_IEN 6'h12
`define ICU_IDX_ROUTE 6'h13
`define ICU_IDX_DIR 6'h14
`define ICU_IDX_LAT 6'h15
`define ICU_IDX_TCTL_BASE 6'h16
`define ICU_IDX_TCNT_BASE 6'h19
// Fields
`define ICU_MODE_LSB 0
`define ICU_TSEL1_LSB 0
`define ICU_TSEL2_LSB 3
`define ICU_TSEL3_LSB 6
`define ICU_TSEL4_LSB 0
`define ICU_TSEL5_LSB 2
`define ICU_ROUTE_U2_BIT 0
`define ICU_ROUTE_U3_BIT 2
`define ICU_TCTL_ON_BIT 0
`define ICU_TCTL_SRC_LSB 1
// Codes and masks
`define ICU_MODE_OFF 4'h0
`define ICU_MODE_FALL 4'h4
`define ICU_MODE_RISE 4'h5
`define ICU_MODE_RISE4 4'h6
`define ICU_MODE_RISE16 4'h7
`define ICU_PS4_MASK 4'h3
`define ICU_PS16_MASK 4'hF
`define ICU_INSTR_DIV_LAST 2'h3
`define ICU_CTRL_MASK 8'hFF
`define ICU_CTRL45_MASK 8'h3F
`define ICU_TSEL_A_MASK 8'hDB
`define ICU_TSEL_B_MASK 8'h0F
`define ICU_UNIT_MASK 8'h1F
`define ICU_ROUTE_MASK 8'h05
`define ICU_TCTL_MASK 8'h07
// Reset values
`define ICU_RST_CTRL 8'h00
`define ICU_RST_VAL 16'h0000
`define ICU_RST_TSEL 8'h00
`define ICU_RST_FLAG 5'h00
`define ICU_RST_ROUTE 8'h01
`define ICU_RST_DIR 5'h1F
`define ICU_RST_TCTL 8'h00
`endif

// File: core/icu_pkg.sv
// Types and shared helper functions of the input capture unit
`default_nettype none
`include "icu_map.svh"
package icu_pkg;
  typedef enum logic [1:0] {
    ICU_SRC_INSTR = 2'b00,
    ICU_SRC_SYS = 2'b01,
    ICU_SRC_SOSC = 2'b10,
    ICU_SRC_EXT = 2'b11
  } icu_clk_src_e;
  typedef logic [15:0] icu_count_t;
  typedef logic [3:0] icu_mode_t;
  function automatic logic icu_is_capture(input icu_mode_t m);
    return (m == `ICU_MODE_FALL) || (m == `ICU_MODE_RISE) ||
           (m == `ICU_MODE_RISE4) || (m == `ICU_MODE_RISE16);
  endfunction : icu_is_capture
  function automatic logic [1:0] icu_timer_index(input logic [1:0] sel);
    return (sel == 2'h3) ? 2'h0 : sel;
  endfunction : icu_timer_index
  function automatic logic icu_at(input logic [5:0] a, input logic [5:0] base, input int off);
    return a == 6'(base + 6'(off));
  endfunction : icu_at
endpackage : icu_pkg
`default_nettype wire

// File: core/icu_timer.sv
// One 16-bit capture time base with clock source choice and sleep hold
`timescale 1ns/1ps
`default_nettype none
`include "icu_map.svh"
module icu_timer (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // Control
  input wire logic on_i,
  input wire icu_pkg::icu_clk_src_e src_i,
  input wire logic sleep_i,
  input wire logic sosc_i,
  input wire logic ext_clk_i,
  input wire logic load_lo_i,
  input wire logic load_hi_i,
  input wire logic [15:0] load_val_i,
  // Count
  output icu_pkg::icu_count_t count_o
);
  logic [1:0] div_r;
  logic sosc_prev_r, ext_prev_r, tick;
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_r <= 2'h0;
      sosc_prev_r <= 1'b0;
      ext_prev_r <= 1'b0;
    end else if (ce_i) begin
      if (!sleep_i) div_r <= div_r + 2'h1;
      sosc_prev_r <= sosc_i;
      ext_prev_r <= ext_clk_i;
    end
  end
  always_comb begin
    case (src_i)
      icu_pkg::ICU_SRC_INSTR: tick = !sleep_i && (div_r == `ICU_INSTR_DIV_LAST);
      icu_pkg::ICU_SRC_SYS: tick = !sleep_i;
      icu_pkg::ICU_SRC_SOSC: tick = sosc_i & ~sosc_prev_r;
      icu_pkg::ICU_SRC_EXT: tick = ext_clk_i & ~ext_prev_r;
      default: tick = 1'b0;
    endcase
  end
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count_o <= 16'h0000;
    end else if (ce_i) begin
      if (load_lo_i || load_hi_i) begin
        if (load_lo_i) count_o[7:0] <= load_val_i[7:0];
        if (load_hi_i) count_o[15:8] <= load_val_i[15:8];
      end else if (on_i && tick) begin
        count_o <= count_o + 16'h0001;
      end
    end
  end
endmodule : icu_timer
`default_nettype wire

// File: core/icu_top.sv
// Five-unit input capture block with three time bases behind a Wishbone slave
//
// The register offsets and the Wishbone slave port were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "icu_map.svh"
module icu_top #(
  parameter int NUM_UNITS = 5,
  parameter int NUM_TIMERS = 3
) (
  // Clock, reset and clock enable
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // Wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Capture pins
  input wire logic unit1_pin_i,
  input wire logic port_b_bit3_pin_i,
  input wire logic port_c_bit1_pin_i,
  input wire logic port_c_bit6_pin_i,
  input wire logic port_b_bit5_pin_i,
  input wire logic unit4_pin_i,
  input wire logic unit5_pin_i,
  // Pin drive when a unit pin is set as output
  output logic [4:0] pin_out_o,
  output logic [4:0] pin_oe_o,
  // Time base clock inputs and power state
  input wire logic sleep_i,
  input wire logic sosc_i,
  input wire logic [2:0] timer_external_clock_in_i,
  // Status
  output logic [4:0] capture_flag_o
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic [7:0] ctrl_r [NUM_UNITS];
  icu_pkg::icu_count_t val_r [NUM_UNITS];
  logic [7:0] tsel_a_r;
  logic [7:0] tsel_b_r;
  logic [4:0] flag_r;
  logic [4:0] flag_nxt;
  logic [4:0] ien_r;
  logic [7:0] route_r;
  logic [4:0] dir_r;
  logic [4:0] lat_r;
  logic [7:0] tctl_r [NUM_TIMERS];
  icu_pkg::icu_count_t tcount [NUM_TIMERS];
  logic [NUM_TIMERS-1:0] tld_lo;
  logic [NUM_TIMERS-1:0] tld_hi;
  logic [1:0] tidx [NUM_UNITS];
  logic [4:0] pad;
  logic [4:0] sensed;
  logic [4:0] cap_evt;
  logic ack_r;
  logic [31:0] dat_r;
  logic [31:0] rd_data;
  logic [4:0] pin_out_r;
  logic [4:0] pin_oe_r;
  logic [5:0] idx;
  logic bus_req;
  logic wr_en;
  logic wr_lane0;
  logic wr_lane1;

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  // Only lane 0 carries the 8-bit registers; lane 1 adds the timer high byte
  assign idx = wb_adr_i[7:2];
  assign bus_req = wb_cyc_i & wb_stb_i & ~ack_r;
  assign wr_en = bus_req & wb_we_i;
  assign wr_lane0 = wr_en & wb_sel_i[0];
  assign wr_lane1 = wr_en & wb_sel_i[1];

  // ****************************************************************
  // Unit control registers
  // ****************************************************************
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int u = 0; u < NUM_UNITS; u++) begin
        ctrl_r[u] <= `ICU_RST_CTRL;
      end
    end else if (ce_i) begin
      for (int u = 0; u < NUM_UNITS; u++) begin
        if (wr_lane0 && icu_pkg::icu_at(idx, `ICU_IDX_CTRL_BASE, u)) begin
          ctrl_r[u] <= wb_dat_i[7:0] & ((u >= 3) ? `ICU_CTRL45_MASK : `ICU_CTRL_MASK);
        end
      end
    end
  end

  // ****************************************************************
  // Timer selection
  // ****************************************************************
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tsel_a_r <= `ICU_RST_TSEL;
      tsel_b_r <= `ICU_RST_TSEL;
    end else if (ce_i) begin
      if (wr_lane0 && idx == `ICU_IDX_TSEL_A) begin
        tsel_a_r <= wb_dat_i[7:0] & `ICU_TSEL_A_MASK;
      end
      if (wr_lane0 && idx == `ICU_IDX_TSEL_B) begin
        tsel_b_r <= wb_dat_i[7:0] & `ICU_TSEL_B_MASK;
      end
    end
  end

  // Each unit reaches its own time base independently
  always_comb begin
    tidx[0] = icu_pkg::icu_timer_index(tsel_a_r[`ICU_TSEL1_LSB +: 2]);
    tidx[1] = icu_pkg::icu_timer_index(tsel_a_r[`ICU_TSEL2_LSB +: 2]);
    tidx[2] = icu_pkg::icu_timer_index(tsel_a_r[`ICU_TSEL3_LSB +: 2]);
    tidx[3] = icu_pkg::icu_timer_index(tsel_b_r[`ICU_TSEL4_LSB +: 2]);
    tidx[4] = icu_pkg::icu_timer_index(tsel_b_r[`ICU_TSEL5_LSB +: 2]);
  end

  // ****************************************************************
  // Time bases
  // ****************************************************************
  for (genvar t = 0; t < NUM_TIMERS; t++) begin : g_timer
    assign tld_lo[t] = wr_lane0 && icu_pkg::icu_at(idx, `ICU_IDX_TCNT_BASE, t);
    assign tld_hi[t] = wr_lane1 && icu_pkg::icu_at(idx, `ICU_IDX_TCNT_BASE, t);
    icu_timer u_timer (
      .clk_sys_i(clk_sys_i),
      .rst_n_i(rst_n_i),
      .ce_i(ce_i),
      .on_i(tctl_r[t][`ICU_TCTL_ON_BIT]),
      .src_i(icu_pkg::icu_clk_src_e'(tctl_r[t][`ICU_TCTL_SRC_LSB +: 2])),
      .sleep_i(sleep_i),
      .sosc_i(sosc_i),
      .ext_clk_i(timer_external_clock_in_i[t]),
      .load_lo_i(tld_lo[t]),
      .load_hi_i(tld_hi[t]),
      .load_val_i(wb_dat_i[15:0]),
      .count_o(tcount[t])
    );
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int t = 0; t < NUM_TIMERS; t++) begin
        tctl_r[t] <= `ICU_RST_TCTL;
      end
    end else if (ce_i) begin
      for (int t = 0; t < NUM_TIMERS; t++) begin
        if (wr_lane0 && icu_pkg::icu_at(idx, `ICU_IDX_TCTL_BASE, t)) begin
          tctl_r[t] <= wb_dat_i[7:0] & `ICU_TCTL_MASK;
        end
      end
    end
  end

  // ****************************************************************
  // Pin routing and direction
  // ****************************************************************
  // An output pin senses its own port latch, so a port write looks like an edge
  always_comb begin
    pad[0] = unit1_pin_i;
    pad[1] = route_r[`ICU_ROUTE_U2_BIT] ? port_c_bit1_pin_i : port_b_bit3_pin_i;
    pad[2] = route_r[`ICU_ROUTE_U3_BIT] ? port_b_bit5_pin_i : port_c_bit6_pin_i;
    pad[3] = unit4_pin_i;
    pad[4] = unit5_pin_i;
    for (int u = 0; u < NUM_UNITS; u++) begin
      sensed[u] = dir_r[u] ? pad[u] : lat_r[u];
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      route_r <= `ICU_RST_ROUTE;
    end else if (ce_i) begin
      if (wr_lane0 && idx == `ICU_IDX_ROUTE) begin
        route_r <= wb_dat_i[7:0] & `ICU_ROUTE_MASK;
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dir_r <= `ICU_RST_DIR;
      lat_r <= 5'h00;
    end else if (ce_i) begin
      if (wr_lane0 && idx == `ICU_IDX_DIR) begin
        dir_r <= wb_dat_i[4:0];
      end
      if (wr_lane0 && idx == `ICU_IDX_LAT) begin
        lat_r <= wb_dat_i[4:0];
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_out_r <= 5'h00;
      pin_oe_r <= 5'h00;
    end else if (ce_i) begin
      pin_out_r <= lat_r;
      pin_oe_r <= ~dir_r;
    end
  end

  // ****************************************************************
  // Edge detection per unit
  // ****************************************************************
  for (genvar u = 0; u < NUM_UNITS; u++) begin : g_unit
    icu_edge_unit u_edge (
      .clk_sys_i(clk_sys_i),
      .rst_n_i(rst_n_i),
      .ce_i(ce_i),
      .pin_i(sensed[u]),
      .mode_i(ctrl_r[u][`ICU_MODE_LSB +: 4]),
      .capture_o(cap_evt[u])
    );
  end

  // ****************************************************************
  // Captured values
  // ****************************************************************
  // A capture beats a software write in the same cycle; the old value is lost
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int u = 0; u < NUM_UNITS; u++) begin
        val_r[u] <= `ICU_RST_VAL;
      end
    end else if (ce_i) begin
      for (int u = 0; u < NUM_UNITS; u++) begin
        if (cap_evt[u]) begin
          val_r[u] <= tcount[tidx[u]];
        end else begin
          if (wr_lane0 && icu_pkg::icu_at(idx, `ICU_IDX_VAL_BASE, 2 * u)) begin
            val_r[u][7:0] <= wb_dat_i[7:0];
          end
          if (wr_lane0 && icu_pkg::icu_at(idx, `ICU_IDX_VAL_BASE, 2 * u + 1)) begin
            val_r[u][15:8] <= wb_dat_i[7:0];
          end
        end
      end
    end
  end

  // ****************************************************************
  // Event flags and enables
  // ****************************************************************
  // Software clears by writing zero; a capture in that cycle still sets
  always_comb begin
    flag_nxt = flag_r;
    if (wr_lane0 && idx == `ICU_IDX_FLAG) begin
      flag_nxt = wb_dat_i[4:0];
    end
    flag_nxt = flag_nxt | cap_evt;
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flag_r <= `ICU_RST_FLAG;
    end else if (ce_i) begin
      flag_r <= flag_nxt;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ien_r <= 5'h00;
    end else if (ce_i) begin
      if (wr_lane0 && idx == `ICU_IDX_IEN) begin
        ien_r <= wb_dat_i[4:0];
      end
    end
  end

  // ****************************************************************
  // Read path
  // ****************************************************************
  always_comb begin
    rd_data = 32'h0000_0000;
    for (int u = 0; u < NUM_UNITS; u++) begin
      if (icu_pkg::icu_at(idx, `ICU_IDX_CTRL_BASE, u)) begin
        rd_data[7:0] = ctrl_r[u];
      end
      if (icu_pkg::icu_at(idx, `ICU_IDX_VAL_BASE, 2 * u)) begin
        rd_data[7:0] = val_r[u][7:0];
      end
      if (icu_pkg::icu_at(idx, `ICU_IDX_VAL_BASE, 2 * u + 1)) begin
        rd_data[7:0] = val_r[u][15:8];
      end
    end
    for (int t = 0; t < NUM_TIMERS; t++) begin
      if (icu_pkg::icu_at(idx, `ICU_IDX_TCTL_BASE, t)) begin
        rd_data[7:0] = tctl_r[t];
      end
      if (icu_pkg::icu_at(idx, `ICU_IDX_TCNT_BASE, t)) begin
        rd_data[15:0] = tcount[t];
      end
    end
    case (idx)
      `ICU_IDX_TSEL_A: rd_data[7:0] = tsel_a_r;
      `ICU_IDX_TSEL_B: rd_data[7:0] = tsel_b_r;
      `ICU_IDX_FLAG: rd_data[4:0] = flag_r;
      `ICU_IDX_IEN: rd_data[4:0] = ien_r;
      `ICU_IDX_ROUTE: rd_data[7:0] = route_r;
      `ICU_IDX_DIR: rd_data[4:0] = dir_r;
      `ICU_IDX_LAT: rd_data[4:0] = lat_r;
      default: rd_data = rd_data;
    endcase
  end

  // ****************************************************************
  // Bus answer
  // ****************************************************************
  // One wait state; ack drops the cycle after it is given, even if stb stays
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ack_r <= 1'b0;
      dat_r <= 32'h0000_0000;
    end else if (ce_i) begin
      ack_r <= bus_req;
      if (bus_req && !wb_we_i) begin
        dat_r <= rd_data;
      end
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;
  assign pin_out_o = pin_out_r;
  assign pin_oe_o = pin_oe_r;
  assign capture_flag_o = flag_r;

endmodule : icu_top
`default_nettype wire
